// *** uci_channel_irq.sv ***
// UART channel interrupt enable, priority, source code and clearing logic behind an APB slave
//
// Behaviour
// - Receive data interrupt: holding full in plain mode, trigger level in FIFO mode.
// - FIFO mode receive interrupt and code hold while level is at or above trigger.
// - Data ready sets on each character push, clears when receive FIFO empties.
// - Line status bits: overrun, top byte errors, transmit empties, any FIFO error.
// - With enhanced unlocked and mask bit 7, clear-to-send rising edge interrupts.
// - With enhanced unlocked and mask bit 6, request-to-send rising edge interrupts.
// - With enhanced unlocked and mask bit 5, Xoff reception interrupts; bit 4 reserved.
// - Modem interrupt when any of four modem delta bits becomes set.
// - Line status interrupt at errored stop bit, again when errored byte reaches top.
// - Errored byte behind a clean top byte shows only the FIFO error flag.
// - Transmit interrupt on empty; FIFO mode below trigger and again on empty.
// - Half-duplex mode withholds second transmit interrupt until shift register empties too.
// - Source register shows highest pending source; lower ones stay queued.
// - FIFO mode receive time-out after four characters plus twelve bits with data waiting.
// - Flow character interrupt on received Xon, Xoff or special character.
// - Pin change interrupt on rising flow pins, pair picked by selection bit.
// - Line status read clears line interrupt; modem read clears modem and pin ones.
// - Holding read clears time-out; receive data clears only below trigger.
// - Transmit interrupt clears on a source register read showing it or a holding register write.
// - Xon/Xoff clear on a source read showing them; special also clears on next character.
// - Six-bit priority codes from line status highest to pin change lowest.
// - Source bit 0 reads 0 while pending, 1 when idle, 1 from reset.
// - Source register top two bits read 1 with FIFOs enabled, else 0.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "uci_defs.svh"
module uci_channel_irq import uci_pkg::*; #(
    parameter int LVL_W = 5
) (
    // Clock and reset
    input  wire logic             REF_CLK_I,
    input  wire logic             NRST_I,
    // APB slave
    input  wire logic             PSEL_I,
    input  wire logic             PENABLE_I,
    input  wire logic             PWRITE_I,
    input  wire logic [6:0]       PADDR_I,
    input  wire logic [31:0]      PWDATA_I,
    output logic      [31:0]      PRDATA_O,
    output logic                  PREADY_O,
    output logic                  PSLVERR_O,
    // Receive path status
    input  wire logic [7:0]       RX_DATA_I,
    input  wire logic [LVL_W-1:0] RX_LEVEL_I,
    input  wire logic [LVL_W-1:0] RX_TRIG_I,
    input  wire logic             RX_PUSH_I,
    input  wire logic             RX_ERR_STOP_I,
    input  wire logic             TOP_NEW_I,
    input  wire logic [2:0]       TOP_ERR_I,
    input  wire logic             OVERRUN_I,
    input  wire logic             FIFO_ERR_I,
    input  wire logic             BIT_TICK_I,
    input  wire logic [3:0]       CHAR_BITS_I,
    // Transmit path status
    input  wire logic [LVL_W-1:0] TX_LEVEL_I,
    input  wire logic [LVL_W-1:0] TX_TRIG_I,
    input  wire logic             TX_SHIFT_EMPTY_I,
    // Flow control and modem detectors
    input  wire logic             XON_DET_I,
    input  wire logic             XOFF_DET_I,
    input  wire logic             SPECIAL_DET_I,
    input  wire logic [3:0]       MODEM_DELTA_I,
    input  wire logic [3:0]       MODEM_STATE_I,
    input  wire logic             RTS_LEVEL_I,
    input  wire logic             DTR_LEVEL_I,
    // Asynchronous flow pins
    input  wire logic             CTS_PIN_N_I,
    input  wire logic             DSR_PIN_N_I,
    // Data path strobes and interrupt request
    output logic                  RX_POP_O,
    output logic                  TX_PUSH_O,
    output logic      [7:0]       TX_DATA_O,
    output logic                  IRQ_O
);
    uci_tmo_if tmo ();

    uci_bus_e         bus_st;
    logic [7:0]       mask;
    logic [3:0]       ctrl;
    uci_code_t        shown_code;
    logic             data_ready;
    logic             ls_flag, tmo_flag, tx_flag;
    logic [3:0]       ms_delta;
    logic             xon_flag, xoff_flag, spc_flag;
    logic             cts_flag, rts_flag;
    logic [1:0]       pin_s1, pin_s2, pin_q;
    logic             out_q;
    logic [LVL_W-1:0] tx_lvl_q;
    logic             tx_all_q;

    logic fifo_en, enh, rs485, flow_sel;
    logic acc_done, rd_done, wr_done;
    logic rd_holding, rd_source, rd_line, rd_modem, wr_holding;
    logic tx_all_empty, tx_ev, in_rise, out_rise;
    logic ls_set, rxd_lvl;
    logic [6:0] pend;
    uci_code_t  cur_code;
    logic [7:0] line_status;
    logic       next_ls, next_tmo, next_tx, next_dr;

    // Register hit on a word-aligned index
    function automatic logic hit(input logic [6:0] addr, input logic [4:0] idx);
        hit = (addr == {idx, 2'b00});
    endfunction : hit

    // Highest-priority pending source to its code
    function automatic uci_code_t encode(input logic [6:0] p);
        if (p[0])      encode = `UCI_CODE_LS;
        else if (p[1]) encode = `UCI_CODE_RXD;
        else if (p[2]) encode = `UCI_CODE_TMO;
        else if (p[3]) encode = `UCI_CODE_TX;
        else if (p[4]) encode = `UCI_CODE_MS;
        else if (p[5]) encode = `UCI_CODE_FLOW;
        else if (p[6]) encode = `UCI_CODE_PIN;
        else           encode = `UCI_CODE_NONE;
    endfunction : encode

    // Control fields
    assign fifo_en  = ctrl[`UCI_C_FIFO_EN];
    assign enh      = ctrl[`UCI_C_ENH];
    assign rs485    = ctrl[`UCI_C_RS485];
    assign flow_sel = ctrl[`UCI_C_FLOW_SEL];

    // Completed transfers and their side-effect strobes
    assign acc_done   = PSEL_I && PENABLE_I && PREADY_O;
    assign rd_done    = acc_done && !PWRITE_I;
    assign wr_done    = acc_done && PWRITE_I;
    assign rd_holding = rd_done && hit(PADDR_I, `UCI_IDX_HOLDING);
    assign rd_source  = rd_done && hit(PADDR_I, `UCI_IDX_SOURCE);
    assign rd_line    = rd_done && hit(PADDR_I, `UCI_IDX_LINE);
    assign rd_modem   = rd_done && hit(PADDR_I, `UCI_IDX_MODEM);
    assign wr_holding = wr_done && hit(PADDR_I, `UCI_IDX_HOLDING);

    // Line status view of the top byte
    assign tx_all_empty = (TX_LEVEL_I == '0) && TX_SHIFT_EMPTY_I;
    assign line_status  = {FIFO_ERR_I, tx_all_empty, TX_LEVEL_I == '0, TOP_ERR_I, OVERRUN_I, data_ready};

    // Transmit events: below trigger, then empty or fully drained
    always_comb begin
        if (!fifo_en) begin
            tx_ev = (tx_lvl_q != '0) && (TX_LEVEL_I == '0);
        end else if (rs485) begin
            tx_ev = ((tx_lvl_q >= TX_TRIG_I) && (TX_LEVEL_I < TX_TRIG_I))
                  || (tx_all_empty && !tx_all_q);
        end else begin
            tx_ev = ((tx_lvl_q >= TX_TRIG_I) && (TX_LEVEL_I < TX_TRIG_I))
                  || ((tx_lvl_q != '0) && (TX_LEVEL_I == '0));
        end
    end

    // Flow pin rising edges, pair chosen by the selection bit
    assign in_rise  = flow_sel ? (pin_s2[1] && !pin_q[1]) : (pin_s2[0] && !pin_q[0]);
    assign out_rise = (flow_sel ? DTR_LEVEL_I : RTS_LEVEL_I) && !out_q;

    // Source conditions gated by the mask
    assign ls_set  = RX_ERR_STOP_I || (TOP_NEW_I && (TOP_ERR_I != 3'h0));
    assign rxd_lvl = fifo_en ? (RX_LEVEL_I >= RX_TRIG_I) : (RX_LEVEL_I != '0);
    assign pend[0] = ls_flag && mask[`UCI_M_LS];
    assign pend[1] = rxd_lvl && mask[`UCI_M_RXD];
    assign pend[2] = tmo_flag && mask[`UCI_M_RXD];
    assign pend[3] = tx_flag && mask[`UCI_M_TXR];
    assign pend[4] = (ms_delta != 4'h0) && mask[`UCI_M_MS];
    assign pend[5] = (xon_flag || xoff_flag || spc_flag) && mask[`UCI_M_FLOW] && enh;
    assign pend[6] = ((cts_flag && mask[`UCI_M_CTS]) || (rts_flag && mask[`UCI_M_RTS])) && enh;
    assign cur_code = encode(pend);

    // Time-out timer hookup
    assign tmo.bit_tick  = BIT_TICK_I;
    assign tmo.char_bits = CHAR_BITS_I;
    assign tmo.waiting   = fifo_en && (RX_LEVEL_I != '0);
    assign tmo.restart   = RX_PUSH_I || rd_holding;

    uci_rx_timeout #(.CNT_W(8)) u_timeout (
        .clk_i   (REF_CLK_I),
        .rst_n_i (NRST_I),
        .tif     (tmo.timer)
    );

    // APB answer: ready one cycle into the access phase
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            bus_st     <= UCI_IDLE;
            PREADY_O   <= 1'b0;
            PSLVERR_O  <= 1'b0;
            PRDATA_O   <= 32'h0000_0000;
            shown_code <= `UCI_CODE_NONE;
        end else begin
            case (bus_st)
                UCI_IDLE: begin
                    if (PSEL_I && PENABLE_I) begin
                        bus_st     <= UCI_ANSWER;
                        PREADY_O   <= 1'b1;
                        PSLVERR_O  <= 1'b0;
                        PRDATA_O   <= 32'h0000_0000;
                        shown_code <= cur_code;
                        if (hit(PADDR_I, `UCI_IDX_HOLDING)) begin
                            PRDATA_O[7:0] <= PWRITE_I ? 8'h00 : RX_DATA_I;
                        end else if (hit(PADDR_I, `UCI_IDX_MASK)) begin
                            PRDATA_O[7:0] <= mask;
                        end else if (hit(PADDR_I, `UCI_IDX_SOURCE)) begin
                            PRDATA_O[7:0] <= {fifo_en, fifo_en, cur_code};
                            PSLVERR_O     <= PWRITE_I;
                        end else if (hit(PADDR_I, `UCI_IDX_LINE)) begin
                            PRDATA_O[7:0] <= line_status;
                            PSLVERR_O     <= PWRITE_I;
                        end else if (hit(PADDR_I, `UCI_IDX_MODEM)) begin
                            PRDATA_O[7:0] <= {MODEM_STATE_I, ms_delta};
                            PSLVERR_O     <= PWRITE_I;
                        end else if (hit(PADDR_I, `UCI_IDX_CTRL)) begin
                            PRDATA_O[3:0] <= ctrl;
                        end else begin
                            PSLVERR_O <= 1'b1;
                        end
                    end
                end
                UCI_ANSWER: begin
                    bus_st    <= UCI_IDLE;
                    PREADY_O  <= 1'b0;
                    PSLVERR_O <= 1'b0;
                end
                default: begin
                    bus_st   <= UCI_IDLE;
                    PREADY_O <= 1'b0;
                end
            endcase
        end
    end

    // Software-written mask and control; enhanced bits locked unless unlocked
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            mask <= `UCI_MASK_RESET;
            ctrl <= `UCI_CTRL_RESET;
        end else if (wr_done) begin
            if (hit(PADDR_I, `UCI_IDX_MASK)) begin
                mask[3:0] <= PWDATA_I[3:0];
                mask[4]   <= 1'b0;
                mask[7:5] <= enh ? PWDATA_I[7:5] : 3'h0;
            end
            if (hit(PADDR_I, `UCI_IDX_CTRL)) begin
                ctrl <= PWDATA_I[3:0];
            end
        end else if (!enh) begin
            mask[7:5] <= 3'h0;
        end
    end

    // Holding register strobes towards the data path
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            RX_POP_O  <= 1'b0;
            TX_PUSH_O <= 1'b0;
            TX_DATA_O <= 8'h00;
        end else begin
            RX_POP_O  <= rd_holding;
            TX_PUSH_O <= wr_holding;
            if (wr_holding) begin
                TX_DATA_O <= PWDATA_I[7:0];
            end
        end
    end

    // Two-stage synchronisers and edge history
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            pin_s1   <= 2'h0;
            pin_s2   <= 2'h0;
            pin_q    <= 2'h0;
            out_q    <= 1'b0;
            tx_lvl_q <= '0;
            tx_all_q <= 1'b1;
        end else begin
            pin_s1   <= {DSR_PIN_N_I, CTS_PIN_N_I};
            pin_s2   <= pin_s1;
            pin_q    <= pin_s2;
            out_q    <= flow_sel ? DTR_LEVEL_I : RTS_LEVEL_I;
            tx_lvl_q <= TX_LEVEL_I;
            tx_all_q <= tx_all_empty;
        end
    end

    // Next values for sticky flags; a set always beats a clear
    assign next_ls  = ls_set || (ls_flag && !rd_line);
    assign next_tmo = tmo.expired || (tmo_flag && !rd_holding);
    assign next_tx  = tx_ev || (tx_flag && !(wr_holding || (rd_source && shown_code == `UCI_CODE_TX)));
    assign next_dr  = RX_PUSH_I || (data_ready && RX_LEVEL_I != '0);

    // Receive, line and transmit flags
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ls_flag    <= 1'b0;
            tmo_flag   <= 1'b0;
            tx_flag    <= 1'b0;
            data_ready <= 1'b0;
        end else begin
            ls_flag    <= next_ls;
            tmo_flag   <= next_tmo;
            tx_flag    <= next_tx;
            data_ready <= next_dr;
        end
    end

    // Modem deltas and flow pin change flags
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ms_delta <= 4'h0;
            cts_flag <= 1'b0;
            rts_flag <= 1'b0;
        end else begin
            ms_delta <= MODEM_DELTA_I | (rd_modem ? 4'h0 : ms_delta);
            cts_flag <= in_rise || (cts_flag && !rd_modem);
            rts_flag <= out_rise || (rts_flag && !rd_modem);
        end
    end

    // Flow character flags cleared by a source register read showing them
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            xon_flag  <= 1'b0;
            xoff_flag <= 1'b0;
            spc_flag  <= 1'b0;
        end else begin
            xon_flag  <= XON_DET_I || (xon_flag && !(rd_source && shown_code == `UCI_CODE_FLOW));
            xoff_flag <= XOFF_DET_I || (xoff_flag && !(rd_source && shown_code == `UCI_CODE_FLOW));
            spc_flag  <= SPECIAL_DET_I
                      || (spc_flag && !RX_PUSH_I && !(rd_source && shown_code == `UCI_CODE_FLOW));
        end
    end

    // Single request line
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= (pend != 7'h00);
        end
    end

    AST_IRQ_IDLE: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (cur_code == `UCI_CODE_NONE) |=> !IRQ_O)
        else $error("request high with nothing pending");
    AST_LS_FIRST: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        pend[0] |-> cur_code == `UCI_CODE_LS)
        else $error("line status not reported first");
    AST_RXD_HOLD: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (fifo_en && mask[`UCI_M_RXD] && !pend[0] && RX_LEVEL_I >= RX_TRIG_I) |-> cur_code == `UCI_CODE_RXD)
        else $error("receive data code missing at trigger");
    AST_LS_CLEAR: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (rd_line && !ls_set) |=> !ls_flag)
        else $error("line status read did not clear");
    AST_TMO_CLEAR: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (rd_holding && !tmo.expired) |=> !tmo_flag)
        else $error("holding read did not clear time-out");
    AST_TX_CLEAR: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (wr_holding && !tx_ev) |=> !tx_flag)
        else $error("holding write did not clear transmit");
    AST_TOP_BITS: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        rd_source |-> PRDATA_O[7:6] == {2{fifo_en}})
        else $error("source top bits wrong");
    AST_NONE_BIT: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        rd_source |-> PRDATA_O[0] == (shown_code == `UCI_CODE_NONE))
        else $error("pending bit wrong");
    AST_DR_SET: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        RX_PUSH_I |=> line_status[0])
        else $error("data ready not set");
    AST_CTS_EDGE: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (!flow_sel && pin_s2[0] && !pin_q[0]) |=> cts_flag)
        else $error("clear-to-send edge lost");
    AST_MS_SET: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (MODEM_DELTA_I != 4'h0) |=> (ms_delta != 4'h0))
        else $error("modem delta lost");
    AST_SPC_CLEAR: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (spc_flag && RX_PUSH_I && !SPECIAL_DET_I) |=> !spc_flag)
        else $error("special not cleared by next character");

    COV_LS:  cover property (@(posedge REF_CLK_I) disable iff (!NRST_I) pend[0] && IRQ_O);
    COV_TX:  cover property (@(posedge REF_CLK_I) disable iff (!NRST_I) rd_source && shown_code == `UCI_CODE_TX);
    COV_PIN: cover property (@(posedge REF_CLK_I) disable iff (!NRST_I) cur_code == `UCI_CODE_PIN);
endmodule : uci_channel_irq

// *** uci_defs.svh ***
// Register indices, field positions, source codes and timer figures for the channel interrupt logic
`ifndef UCI_DEFS_SVH
`define UCI_DEFS_SVH

// Register indices (byte address is four times the index)
`define UCI_IDX_HOLDING   5'h00
`define UCI_IDX_MASK      5'h01
`define UCI_IDX_SOURCE    5'h02
`define UCI_IDX_LINE      5'h05
`define UCI_IDX_MODEM     5'h06
`define UCI_IDX_CTRL      5'h10

// Interrupt mask bit positions
`define UCI_M_RXD         0
`define UCI_M_TXR         1
`define UCI_M_LS          2
`define UCI_M_MS          3
`define UCI_M_FLOW        5
`define UCI_M_RTS         6
`define UCI_M_CTS         7
`define UCI_M_ENH_LSB     5

// Control register bit positions
`define UCI_C_FIFO_EN     0
`define UCI_C_ENH         1
`define UCI_C_RS485       2
`define UCI_C_FLOW_SEL    3

// Reset values
`define UCI_MASK_RESET    8'h00
`define UCI_CTRL_RESET    4'h0

// Interrupt source codes, bits 5:0 of the source register
`define UCI_CODE_LS       6'h06
`define UCI_CODE_RXD      6'h04
`define UCI_CODE_TMO      6'h0c
`define UCI_CODE_TX       6'h02
`define UCI_CODE_MS       6'h00
`define UCI_CODE_FLOW     6'h10
`define UCI_CODE_PIN      6'h20
`define UCI_CODE_NONE     6'h01

// Receive time-out: characters plus extra bit times
`define UCI_TMO_CHARS     8'h04
`define UCI_TMO_EXTRA     8'h0c

`endif

// *** uci_pkg.sv ***
// Types shared by the channel interrupt logic
package uci_pkg;
    typedef enum logic {UCI_IDLE, UCI_ANSWER} uci_bus_e;
    typedef logic [5:0] uci_code_t;
endpackage : uci_pkg

// *** uci_tmo_if.sv ***
// Link between the interrupt logic and its receive time-out timer
`timescale 1ns/1ps
interface uci_tmo_if;
    logic       bit_tick;
    logic [3:0] char_bits;
    logic       waiting;
    logic       restart;
    logic       expired;
    modport timer (input bit_tick, input char_bits, input waiting, input restart, output expired);
    modport user  (output bit_tick, output char_bits, output waiting, output restart, input expired);
endinterface : uci_tmo_if

// *** uci_rx_timeout.sv ***
// Receive time-out timer counting character and bit times
`timescale 1ns/1ps
`include "uci_defs.svh"
module uci_rx_timeout import uci_pkg::*; #(
    parameter int CNT_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    uci_tmo_if.timer tif
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] limit;

    // Delay of four characters plus twelve bits
    assign limit = CNT_W'(`UCI_TMO_CHARS * {4'h0, tif.char_bits} + `UCI_TMO_EXTRA);

    // Bit-time counter, held at the limit once reached
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count       <= '0;
            tif.expired <= 1'b0;
        end else if (tif.restart || !tif.waiting) begin
            count       <= '0;
            tif.expired <= 1'b0;
        end else begin
            if (tif.bit_tick && count != limit) begin
                count <= count + CNT_W'(1);
            end
            tif.expired <= tif.bit_tick && (count == limit - CNT_W'(1));
        end
    end

    AST_TMO_LIMIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tif.expired |-> ($past(count) == limit - CNT_W'(1)) && $past(tif.bit_tick))
        else $error("time-out fired at the wrong count");
    COV_TMO: cover property (@(posedge clk_i) disable iff (!rst_n_i) tif.expired);
endmodule : uci_rx_timeout

// *** uci_far_end.sv ***
// Behavioural model of the receive, transmit and modem paths beside the channel
`timescale 1ns/1ps
module uci_far_end (
    // Clock
    input wire logic clk_i
);
    // Levels, triggers and quiet lines: [0] shift empty, [1] bit tick, [2] overrun, [3] fifo error
    logic [4:0] rx_level = 5'h00, tx_level = 5'h00, rx_trig = 5'h04, tx_trig = 5'h02;
    logic [2:0] top_err  = 3'h0;
    logic [7:0] lines    = 8'h01;
    logic [7:0] pulses   = 8'h00;
    // Receive top byte, frame size and modem levels
    logic [7:0] rx_data     = 8'h00;
    logic [3:0] char_bits   = 4'h8;
    logic [3:0] modem_state = 4'h0;
    // One-cycle strobe launched just after a clock edge
    task pulse(input int k);
        @(posedge clk_i);
        pulses[k] <= 1'b1;
        @(posedge clk_i);
        pulses[k] <= 1'b0;
    endtask : pulse
endmodule : uci_far_end

// *** testbench.sv ***
// Self-checking bench for the channel interrupt logic over APB
`timescale 1ns/1ps
`include "uci_defs.svh"
module testbench;
    import uci_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [6:0] paddr = 7'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, perr, e, irq, rx_pop, tx_push;
    logic [7:0] tx_data;
    int mismatches = 0, samples_checked = 0;
    localparam logic [6:0] HOLD = {`UCI_IDX_HOLDING, 2'b00}, MASK = {`UCI_IDX_MASK, 2'b00};
    localparam logic [6:0] SRC = {`UCI_IDX_SOURCE, 2'b00}, LINE = {`UCI_IDX_LINE, 2'b00};
    localparam logic [6:0] MODEM = {`UCI_IDX_MODEM, 2'b00}, CTRL = {`UCI_IDX_CTRL, 2'b00};
    uci_far_end far (.clk_i(clk));
    uci_channel_irq dut (.REF_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
        .RX_DATA_I(far.rx_data), .RX_LEVEL_I(far.rx_level), .RX_TRIG_I(far.rx_trig), .RX_PUSH_I(far.pulses[0]),
        .RX_ERR_STOP_I(far.pulses[1]), .TOP_NEW_I(far.pulses[2]), .TOP_ERR_I(far.top_err),
        .OVERRUN_I(far.lines[2]), .FIFO_ERR_I(far.lines[3]), .BIT_TICK_I(far.lines[1]), .CHAR_BITS_I(far.char_bits),
        .TX_LEVEL_I(far.tx_level), .TX_TRIG_I(far.tx_trig), .TX_SHIFT_EMPTY_I(far.lines[0]),
        .XON_DET_I(far.pulses[5]), .XOFF_DET_I(far.pulses[3]), .SPECIAL_DET_I(far.pulses[6]),
        .MODEM_DELTA_I({3'h0, far.pulses[4]}), .MODEM_STATE_I(far.modem_state), .RTS_LEVEL_I(far.lines[4]),
        .DTR_LEVEL_I(far.lines[5]), .CTS_PIN_N_I(far.lines[6]), .DSR_PIN_N_I(far.lines[7]),
        .RX_POP_O(rx_pop), .TX_PUSH_O(tx_push), .TX_DATA_O(tx_data), .IRQ_O(irq));
    // Clock generation
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    // APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [6:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) mismatches++;
        q = prdata;
        e = perr;
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb
    task rd(input logic [6:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask : rd
    task end_of_test;
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
    // Test sequence
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(SRC, 32'h01);
        rd(MASK, 32'h00);
        apb(1'b0, 7'h7c, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, CTRL, 32'h3);
        rd(SRC, 32'hc1);
        far.rx_level <= 5'h02;
        far.pulse(0);
        rd(LINE, 32'h61);
        chk({31'h0, irq}, 32'h0);
        $display("polled mode done");
        apb(1'b1, MASK, 32'h08);
        far.pulse(4);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        rd(SRC, {26'h3, `UCI_CODE_MS});
        rd(MODEM, 32'h01);
        rd(SRC, 32'hc1);
        apb(1'b1, MASK, 32'h07);
        far.rx_level <= 5'h04;
        far.pulse(1);
        rd(SRC, {26'h3, `UCI_CODE_LS});
        rd(LINE, 32'h61);
        rd(SRC, {26'h3, `UCI_CODE_RXD});
        far.rx_level <= 5'h03;
        rd(SRC, 32'hc1);
        far.top_err <= 3'h1;
        far.pulse(2);
        rd(SRC, {26'h3, `UCI_CODE_LS});
        rd(LINE, 32'h65);
        $display("receive priority done");
        far.tx_level <= 5'h03;
        far.pulse(7);
        far.tx_level <= 5'h01;
        rd(SRC, {26'h3, `UCI_CODE_TX});
        rd(SRC, 32'hc1);
        far.tx_level <= 5'h00;
        rd(SRC, {26'h3, `UCI_CODE_TX});
        apb(1'b1, HOLD, 32'h5a);
        rd(SRC, 32'hc1);
        chk({24'h0, tx_data}, 32'h5a);
        $display("transmit done");
        apb(1'b1, MASK, 32'h20);
        far.pulse(3);
        rd(SRC, {26'h3, `UCI_CODE_FLOW});
        rd(SRC, 32'hc1);
        $display("flow character done");
        apb(1'b1, MASK, 32'hc0);
        far.modem_state <= 4'h3;
        far.lines[6] <= 1'b1;
        far.lines[4] <= 1'b1;
        repeat (6) @(posedge clk);
        rd(SRC, {26'h3, `UCI_CODE_PIN});
        rd(MODEM, 32'h30);
        rd(SRC, 32'hc1);
        far.lines[2] <= 1'b1;
        far.lines[3] <= 1'b1;
        rd(LINE, 32'he7);
        far.rx_data <= 8'ha5;
        rd(HOLD, 32'ha5);
        @(posedge clk);
        chk({31'h0, rx_pop}, 32'h1);
        $display("pin change and holding done");
        end_of_test();
    end
endmodule : testbench
